/* File: logic/usb_core_pkg.sv */
// Purpose: Shared constants and types for the full-speed USB device core
// Assumes: 50 MHz system clock, byte-wide CPU ports in external data space
// Notes:   Cycle counts are derived from times written in microseconds
package usb_core_pkg;

  // CPU byte ports
  localparam logic [15:0] CFG_ADDR  = 16'h6000;  // Configuration byte
  localparam logic [15:0] RDAT_ADDR = 16'h6001;  // Read data port
  localparam logic [15:0] WDAT_ADDR = 16'h6002;  // Write data port
  localparam logic [15:0] CMD_ADDR  = 16'h6003;  // Command port
  localparam logic [7:0]  CFG_RESET = 8'h00;     // Configuration after reset
  localparam int          CFG_PULLUP_BIT = 5;    // Pull-up source select

  // Command codes
  localparam logic [7:0] CMD_EP_SEL_LO = 8'h00;  // Select endpoint, first
  localparam logic [7:0] CMD_EP_SEL_HI = 8'h06;  // Select endpoint, last
  localparam logic [7:0] CMD_EP_CLR_LO = 8'h40;  // Select and clear, first
  localparam logic [7:0] CMD_EP_CLR_HI = 8'h46;  // Select and clear, last
  localparam logic [7:0] CMD_SET_ADDR  = 8'hd0;  // Address and enable
  localparam logic [7:0] CMD_PORT_ST   = 8'he0;  // Embedded port status
  localparam logic [7:0] CMD_BUFFER    = 8'hf0;  // Buffer data
  localparam logic [7:0] CMD_INT_REG   = 8'hf4;  // Interrupt register
  localparam logic [7:0] CMD_FRAME     = 8'hf5;  // Frame number
  localparam logic [7:0] CMD_CHIP_ID   = 8'hfd;  // Chip identification
  localparam logic [7:0] CMD_DEV_ST    = 8'hfe;  // Device status

  // Device status bit positions
  localparam int DS_CONNECT  = 0;
  localparam int DS_CONN_CHG = 1;
  localparam int DS_SUSP     = 2;
  localparam int DS_SUSP_CHG = 3;
  localparam int DS_BUS_RST  = 4;
  localparam int INT_DEV_BIT = 10;  // Device status change in interrupt word

  // Endpoints
  localparam int NUM_EP     = 7;   // Physical endpoints 0.0 to 0.6
  localparam int CTRL_BYTES = 8;   // Control buffer, each direction
  localparam int INT_BYTES  = 8;   // Interrupt IN buffers
  localparam int BULK_BYTES = 64;  // Bulk buffers, each direction
  localparam int EP_BULK_OUT = 5;  // Physical index of bulk OUT

  // Timing
  localparam int CLK_KHZ         = 50000;
  localparam int IDLE_SUSPEND_US = 3000;  // Bus idle before suspend
  localparam int CLK_RELEASE_US  = 2000;  // Suspend before clock release
  localparam int RESUME_DRIVE_US = 2000;  // Length of upstream resume
  localparam int SUSPEND_CYC = IDLE_SUSPEND_US * CLK_KHZ / 1000;
  localparam int RELEASE_CYC = CLK_RELEASE_US * CLK_KHZ / 1000;
  localparam int RESUME_CYC  = RESUME_DRIVE_US * CLK_KHZ / 1000;
  localparam int CNT_W       = 18;

  // Data path buffer
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 4;

  // Power states, one-hot
  typedef enum logic [4:0] {
    ST_RUN       = 5'b00001,
    ST_SUSP      = 5'b00010,
    ST_SUSP_OFF  = 5'b00100,
    ST_WAKE_LOCK = 5'b01000,
    ST_RESUME_TX = 5'b10000
  } pwr_e;

endpackage

/* File: logic/usb_byte_fifo.sv */
// Purpose: Small synchronous FIFO for write-buffer bytes
// Assumes: Single clock, valid/ready on both sides
// Notes:   Ready, valid and head word are registered
`timescale 1ns/100ps
module usb_byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;    // Storage
    logic [AW-1:0]               wr;     // Write index
    logic [AW-1:0]               rd;     // Read index
    logic [AW:0]                 cnt;    // Occupancy
    logic                        room;   // Space for one more word
    logic                        vld;    // Head holds data
    logic [WIDTH-1:0]            head;   // Registered head word
  } fifo_s;

  fifo_s r;       // Current state
  fifo_s next_r;  // Next state
  logic  push;
  logic  pop;

  // Pointer and occupancy update
  always_comb begin
    next_r = r;
    push   = in_valid & r.room;
    pop    = out_ready & r.vld;
    if (push) begin
      next_r.mem[r.wr] = in_data;
      next_r.wr = (r.wr == AW'(DEPTH - 1)) ? '0 : r.wr + 1'b1;
    end
    if (pop) begin
      next_r.rd = (r.rd == AW'(DEPTH - 1)) ? '0 : r.rd + 1'b1;
    end
    if (push && !pop) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pop && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
    next_r.room  = (next_r.cnt != (AW + 1)'(DEPTH));
    next_r.vld   = (next_r.cnt != '0);
    next_r.head  = next_r.mem[next_r.rd];  // Keeps the output off the read mux
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r       <= '0;
      r.room  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign in_ready  = r.room;
  assign out_valid = r.vld;
  assign out_data  = r.head;

endmodule // usb_byte_fifo

/* File: logic/usb_fs_device_core.sv */
// Purpose: Full-speed USB device core: command ports, suspend and wake
// Assumes: Link pins are asynchronous; SIE strobes share clk_sys
// Notes:   CPU strobes are one clk_sys cycle wide
`timescale 1ns/100ps

// Notes on behaviour
// - Device only, full speed, CPU services functions
// - Endpoint 0 control, 8 bytes, 0.0/0.1
// - Endpoints 1-3 interrupt IN, 8 bytes
// - Endpoint 4 bulk, 64 bytes, 0.5/0.6
// - Interrupt on transaction or new status
// - Suspend after 3 ms idle bus
// - Release clock request 2 ms after suspend
// - Resume after release: request clock, await lock
// - Resume before release: leave suspend at once
// - Wake command: leave suspend, send resume
// - Early wake waits until 2 ms suspended
// - Soft attach pulls D+ high
// - Config bit 5 picks external or internal
// - Command 6003, write 6002, read 6001
// - Command byte then its fixed data phase
// - F5h returns two-byte frame number
// - E0h reads or writes embedded port status
// - D0h write sets address and enable
// - 00h-06h select endpoints, optional status read
// - 40h-46h select, status, clear endpoint interrupt
// - F4h returns interrupt word; select-and-clear clears
// - Device status read clears change bits
module usb_fs_device_core #(
  parameter int          SUSPEND_CYC = usb_core_pkg::SUSPEND_CYC,
  parameter int          RELEASE_CYC = usb_core_pkg::RELEASE_CYC,
  parameter int          RESUME_CYC  = usb_core_pkg::RESUME_CYC,
  parameter logic [11:0] CHIP_ID     = 12'h5a3,  // Value is arbitrary
  parameter int          FIFO_DEPTH  = usb_core_pkg::FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // CPU byte ports
  input  wire logic [15:0] cpu_addr,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  input  wire logic [7:0]  cpu_wdata,
  output logic [7:0]       cpu_rdata,
  output logic             cpu_wr_ready,
  output logic             cpu_irq,
  // Upstream link pins
  input  wire logic        usb_activity,
  input  wire logic        usb_bus_reset,
  output logic             resume_drive,
  output logic             pullup_int,
  output logic             pullup_ext,
  input  wire logic        soft_attach_n,
  // Power, clock and reset controller
  output logic             clk_req_n,
  input  wire logic        pll_lock,
  input  wire logic        remote_wakeup_request_n,
  output logic             usb_suspended,
  // Serial engine side
  input  wire logic [10:0] frame_num,
  input  wire logic [6:0]  ep_done,
  output logic [6:0]       func_addr,
  output logic             func_enable,
  output logic [7:0]       port_status,
  output logic [7:0]       tx_data,
  output logic             tx_valid,
  input  wire logic        tx_ready
);
  import usb_core_pkg::*;

  localparam logic [CNT_W-1:0] SUSP_LAST = CNT_W'(SUSPEND_CYC - 1);
  localparam logic [CNT_W-1:0] REL_LAST  = CNT_W'(RELEASE_CYC - 1);
  localparam logic [CNT_W-1:0] RES_LAST  = CNT_W'(RESUME_CYC - 1);

  typedef struct packed {
    pwr_e             pwr;        // Power state
    logic [CNT_W-1:0] cnt;        // Idle, suspend or resume timer
    logic [1:0]       act_sy;     // Bus activity synchroniser
    logic [1:0]       brst_sy;    // Bus reset synchroniser
    logic [1:0]       pll_sy;     // Lock synchroniser
    logic [1:0]       wk_sy;      // Wake request synchroniser
    logic [1:0]       att_sy;     // Attach synchroniser
    logic             brst_d;     // Bus reset edge history
    logic             wake_pend;  // Wake asked by CPU
    logic             wake_flag;  // Clock asked for a wake
    logic             clk_req_n;
    logic             resume;
    logic             pull_int;
    logic             pull_ext;
    logic             irq;
    logic [7:0]       cfg;        // Configuration byte
    logic [7:0]       cmd;        // Current command
    logic             idx;        // Byte index of data phase
    logic [7:0]       rdata;
    logic [6:0]       ep_irq;     // Endpoint interrupt bits
    logic             dev_chg;    // Device status change
    logic             connect;
    logic             conn_chg;
    logic             susp_chg;
    logic             bus_rst;
    logic [6:0]       addr;
    logic             fen;
    logic [7:0]       port_st;
    logic             susp;       // Suspended bit
  } core_s;

  core_s       r;          // Current state
  core_s       next_r;     // Next state
  logic        activity;   // Synchronised bus activity
  logic        locked;     // Synchronised lock
  logic        wk_req;     // Synchronised wake request
  logic        attach;     // Synchronised attach
  logic        brst_edge;  // Bus reset start
  logic        wr_cmd;     // Command port write
  logic        wr_dat;     // Data port write
  logic        rd_dat;     // Data port read
  logic        susp_tgl;   // Suspended bit toggles
  logic        in_susp;    // Suspended bit
  logic        fifo_push;
  logic        fifo_ready;
  logic [7:0]  resp;       // Byte answered to a data read
  logic [15:0] int_word;   // Interrupt register
  logic [6:0]  ep_clr;     // Endpoint bits to clear
  logic        st_clr;     // Device status read
  logic        conn_evt;   // Connect bit changes

  assign activity  = r.act_sy[1];
  assign locked    = r.pll_sy[1];
  assign wk_req    = ~r.wk_sy[1];
  assign attach    = ~r.att_sy[1];
  assign brst_edge = r.brst_sy[1] & ~r.brst_d;
  assign in_susp   = r.susp;  // Registered so the pin comes from a flop
  assign wr_cmd    = cpu_wr && (cpu_addr == CMD_ADDR);
  assign wr_dat    = cpu_wr && (cpu_addr == WDAT_ADDR);
  assign rd_dat    = cpu_rd && (cpu_addr == RDAT_ADDR);
  assign int_word  = {5'h00, r.dev_chg, 3'h0, r.ep_irq};
  assign fifo_push = wr_dat && (r.cmd == CMD_BUFFER);
  assign conn_evt  = wr_dat && (r.cmd == CMD_DEV_ST) && (cpu_wdata[DS_CONNECT] != r.connect);

  // Endpoint size in 8-byte units
  function automatic logic [6:0] ep_units(input logic [2:0] ep);
    if (ep >= 3'(EP_BULK_OUT)) begin
      ep_units = 7'(BULK_BYTES / 8);
    end else if (ep >= 3'd2) begin
      ep_units = 7'(INT_BYTES / 8);
    end else begin
      ep_units = 7'(CTRL_BYTES / 8);
    end
  endfunction

  // Answer byte for the current command and index
  always_comb begin
    case (r.cmd)
      CMD_FRAME:   resp = r.idx ? {5'h00, frame_num[10:8]} : frame_num[7:0];
      CMD_INT_REG: resp = r.idx ? int_word[15:8] : int_word[7:0];
      CMD_CHIP_ID: resp = r.idx ? {4'h0, CHIP_ID[11:8]} : CHIP_ID[7:0];
      CMD_PORT_ST: resp = r.port_st;
      CMD_DEV_ST:  resp = {3'h0, r.bus_rst, r.susp_chg, in_susp, r.conn_chg, r.connect};
      default: begin
        if ((r.cmd <= CMD_EP_SEL_HI) ||
            ((r.cmd >= CMD_EP_CLR_LO) && (r.cmd <= CMD_EP_CLR_HI))) begin
          resp = {ep_units(r.cmd[2:0]), r.ep_irq[r.cmd[2:0]]};
        end else begin
          resp = 8'h00;  // Reserved or write-only codes
        end
      end
    endcase
  end

  // Next-state logic
  always_comb begin
    next_r         = r;
    susp_tgl       = 1'b0;
    ep_clr         = '0;
    st_clr         = 1'b0;
    next_r.act_sy  = {r.act_sy[0], usb_activity};
    next_r.brst_sy = {r.brst_sy[0], usb_bus_reset};
    next_r.pll_sy  = {r.pll_sy[0], pll_lock};
    next_r.wk_sy   = {r.wk_sy[0], remote_wakeup_request_n};
    next_r.att_sy  = {r.att_sy[0], soft_attach_n};
    next_r.brst_d  = r.brst_sy[1];
    next_r.cnt     = r.cnt + 1'b1;
    // Power state machine
    case (r.pwr)
      ST_RUN: begin
        if (activity) begin
          next_r.cnt = '0;
        end else if (r.cnt == SUSP_LAST) begin
          next_r.pwr = ST_SUSP;
          next_r.cnt = '0;
          susp_tgl   = 1'b1;
        end
      end
      ST_SUSP: begin
        if (activity) begin
          next_r.pwr = ST_RUN;
          next_r.cnt = '0;
          susp_tgl   = 1'b1;
        end else if (r.cnt == REL_LAST) begin
          next_r.cnt = '0;
          if (r.wake_pend || wk_req) begin
            next_r.pwr       = ST_RESUME_TX;
            next_r.wake_pend = 1'b0;
            susp_tgl         = 1'b1;
          end else begin
            next_r.pwr       = ST_SUSP_OFF;
            next_r.clk_req_n = 1'b1;
          end
        end
      end
      ST_SUSP_OFF: begin
        next_r.cnt = '0;
        if (activity || wk_req || r.wake_pend) begin
          next_r.pwr       = ST_WAKE_LOCK;
          next_r.clk_req_n = 1'b0;
          next_r.wake_flag = !activity;
          next_r.wake_pend = 1'b0;
        end
      end
      ST_WAKE_LOCK: begin
        next_r.cnt = '0;
        if (locked) begin
          next_r.pwr = r.wake_flag ? ST_RESUME_TX : ST_RUN;
          susp_tgl   = 1'b1;
        end
      end
      ST_RESUME_TX: begin
        if (r.cnt == RES_LAST) begin
          next_r.pwr = ST_RUN;
          next_r.cnt = '0;
        end
      end
      default: begin
        next_r.pwr = ST_RUN;
        next_r.cnt = '0;
      end
    endcase
    next_r.resume = (next_r.pwr == ST_RESUME_TX);
    next_r.susp   = (next_r.pwr == ST_SUSP) || (next_r.pwr == ST_SUSP_OFF) || (next_r.pwr == ST_WAKE_LOCK);
    // Command port
    if (wr_cmd) begin
      next_r.cmd = cpu_wdata;
      next_r.idx = 1'b0;
      if ((cpu_wdata >= CMD_EP_CLR_LO) && (cpu_wdata <= CMD_EP_CLR_HI)) begin
        ep_clr[cpu_wdata[2:0]] = 1'b1;
      end
    end
    // Write data phase
    if (wr_dat) begin
      case (r.cmd)
        CMD_SET_ADDR: begin
          next_r.addr = cpu_wdata[6:0];
          next_r.fen  = cpu_wdata[7];
        end
        CMD_PORT_ST: next_r.port_st = cpu_wdata;
        CMD_DEV_ST: begin
          next_r.connect = cpu_wdata[DS_CONNECT];
          if (!cpu_wdata[DS_SUSP] && in_susp) begin
            next_r.wake_pend = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Read ports
    if (rd_dat) begin
      next_r.rdata = resp;
      next_r.idx   = ~r.idx;
      st_clr       = (r.cmd == CMD_DEV_ST);
    end else if (cpu_rd && (cpu_addr == CFG_ADDR)) begin
      next_r.rdata = r.cfg;
    end else if (cpu_rd) begin
      next_r.rdata = 8'h00;
    end
    if (cpu_wr && (cpu_addr == CFG_ADDR)) begin
      next_r.cfg = cpu_wdata;
    end
    // Sticky events, set wins over clear
    next_r.ep_irq   = (r.ep_irq & ~ep_clr) | ep_done;
    next_r.conn_chg = (r.conn_chg & ~st_clr) | conn_evt;
    next_r.susp_chg = (r.susp_chg & ~st_clr) | susp_tgl;
    next_r.bus_rst  = (r.bus_rst & ~st_clr) | brst_edge;
    next_r.dev_chg  = (r.dev_chg & ~st_clr) | susp_tgl | brst_edge | conn_evt;
    if (brst_edge) begin
      next_r.addr = '0;
      next_r.fen  = 1'b0;
    end
    next_r.irq      = (|next_r.ep_irq) | next_r.dev_chg;
    next_r.pull_int = attach & ~r.cfg[CFG_PULLUP_BIT];
    next_r.pull_ext = attach & r.cfg[CFG_PULLUP_BIT];
  end

  // State register
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r        <= '0;
      r.pwr    <= ST_RUN;
      r.wk_sy  <= 2'b11;
      r.att_sy <= 2'b11;
      r.cfg    <= CFG_RESET;
    end else begin
      r <= next_r;
    end
  end

  // Buffer write path towards the serial engine
  usb_byte_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n),
    .in_valid  (fifo_push),
    .in_ready  (fifo_ready),
    .in_data   (cpu_wdata),
    .out_valid (tx_valid),
    .out_ready (tx_ready),
    .out_data  (tx_data)
  );

  // Outputs, device only at full speed with CPU-serviced functions
  assign cpu_rdata     = r.rdata;
  assign cpu_wr_ready  = fifo_ready;
  assign cpu_irq       = r.irq;
  assign resume_drive  = r.resume;
  assign pullup_int    = r.pull_int;
  assign pullup_ext    = r.pull_ext;
  assign clk_req_n     = r.clk_req_n;
  assign usb_suspended = in_susp;
  assign func_addr     = r.addr;
  assign func_enable   = r.fen;
  assign port_status   = r.port_st;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  susp_entry_a:
    assert property (r.pwr == ST_RUN && !activity && r.cnt == SUSP_LAST |=> r.pwr == ST_SUSP)
      else $error("Suspend not entered after idle time");
  clk_release_a:
    assert property (r.pwr == ST_SUSP && !activity && r.cnt == REL_LAST && !r.wake_pend && !wk_req
                     |=> clk_req_n && r.pwr == ST_SUSP_OFF)
      else $error("Clock request not released");
  lock_wait_a:
    assert property (r.pwr == ST_WAKE_LOCK && !locked |=> r.pwr == ST_WAKE_LOCK && !clk_req_n)
      else $error("Left lock wait without lock");
  early_resume_a:
    assert property (r.pwr == ST_SUSP && activity |=> r.pwr == ST_RUN && !clk_req_n)
      else $error("Early host resume not immediate");
  wake_hold_a:
    assert property (r.pwr == ST_SUSP && r.cnt != REL_LAST |=> !resume_drive)
      else $error("Resume sent before suspend time");
  wake_send_a:
    assert property (r.pwr == ST_SUSP && !activity && r.cnt == REL_LAST && r.wake_pend
                     |=> resume_drive && !usb_suspended ##1 resume_drive)
      else $error("Wake command gave no resume");
  pullup_sel_a:
    assert property (attach && !r.cfg[CFG_PULLUP_BIT] |=> pullup_int && !pullup_ext)
      else $error("Wrong pull-up source");
  irq_event_a:
    assert property (ep_done != 7'h00 |=> cpu_irq)
      else $error("Interrupt missing after transaction");
  frame_read_a:
    assert property (rd_dat && r.cmd == CMD_FRAME && !r.idx |=> cpu_rdata == $past(frame_num[7:0]))
      else $error("Frame number low byte wrong");
  status_clr_a:
    assert property (rd_dat && r.cmd == CMD_DEV_ST && !brst_edge && !susp_tgl |=> !r.bus_rst && !r.susp_chg)
      else $error("Status change bits not cleared");
  ep_clear_a:
    assert property (wr_cmd && cpu_wdata == CMD_EP_CLR_LO && !ep_done[0] |=> !r.ep_irq[0])
      else $error("Endpoint interrupt not cleared");
  addr_set_a:
    assert property (wr_dat && r.cmd == CMD_SET_ADDR && !brst_edge |=> func_addr == $past(cpu_wdata[6:0]))
      else $error("Device address not written");

  susp_seen_c:   cover property (r.pwr == ST_SUSP ##1 r.pwr == ST_SUSP_OFF);
  lock_seen_c:   cover property (r.pwr == ST_WAKE_LOCK ##1 r.pwr == ST_RUN);
  resume_seen_c: cover property (r.pwr == ST_RESUME_TX ##1 r.pwr == ST_RUN);

endmodule // usb_fs_device_core

/* File: sim/usb_host_model.sv */
// Purpose: Host and serial engine stand-in facing the USB device core
// Assumes: One clock; the bench steers it through plain inputs
// Notes:   Frame number moves only when the bus restarts
`timescale 1ns/100ps
module usb_host_model (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Bench controls
  input  wire logic       bus_on,
  input  wire logic       stall,
  input  wire logic [6:0] done_req,
  // Toward the core
  output logic            usb_activity,
  output logic [10:0]     frame_num,
  output logic [6:0]      ep_done,
  output logic            tx_ready
);
  logic bus_d;  // Bus level one cycle back
  // Done pulses last one cycle; frame steps on each bus restart
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      frame_num <= 11'h5a5;
      ep_done   <= 7'h00;
      bus_d     <= 1'b1;
    end else begin
      ep_done <= done_req;
      bus_d   <= bus_on;
      if (bus_on && !bus_d) begin
        frame_num <= frame_num + 11'h001;
      end
    end
  end
  assign usb_activity = bus_on;  // Level while traffic flows
  assign tx_ready     = !stall;  // A stall lets the buffer fill
endmodule // usb_host_model

/* File: sim/usb_fs_device_core_tb.sv */
// Purpose: Self-checking bench for the USB device core
// Assumes: Short suspend and release counts
// Notes:   Inputs move on the falling edge
`timescale 1ns/100ps
module usb_fs_device_core_tb;
  import usb_core_pkg::*;
  localparam int SUSP = 40;  // Idle cycles before suspend
  localparam int REL  = 20;  // Suspended cycles before release
  logic        clk_sys = 1'b0;
  logic        rst_n = 1'b0;
  logic [15:0] cpu_addr = 16'h0000;
  logic [7:0]  cpu_wdata = 8'h00;
  logic        cpu_wr = 1'b0;
  logic        cpu_rd = 1'b0;
  logic        soft_attach_n = 1'b1;
  logic        pll_lock = 1'b1;
  logic        bus_rst = 1'b0;
  logic        wake_n = 1'b1;
  logic        bus_on = 1'b1;
  logic        stall = 1'b0;
  logic [6:0]  done_req = 7'h00;
  logic [7:0]  cpu_rdata, port_status, tx_data, v;
  logic        cpu_wr_ready, cpu_irq, resume_drive, pullup_int, pullup_ext, clk_req_n;
  logic        usb_suspended, func_enable, tx_valid, tx_ready, usb_activity;
  logic [10:0] frame_num;
  logic [6:0]  ep_done, func_addr;
  int          bad_count = 0;
  int          n_tests = 0;
  int          n;
  // Free-running system clock
  always #10 clk_sys = ~clk_sys;
  usb_host_model u_host (.clk_sys, .rst_n, .bus_on, .stall, .done_req, .usb_activity, .frame_num,
    .ep_done, .tx_ready);
  usb_fs_device_core #(.SUSPEND_CYC(SUSP), .RELEASE_CYC(REL), .RESUME_CYC(8)) u_dut (.clk_sys, .rst_n,
    .cpu_addr, .cpu_wr, .cpu_rd, .cpu_wdata, .cpu_rdata, .cpu_wr_ready, .cpu_irq, .usb_activity,
    .usb_bus_reset(bus_rst), .resume_drive, .pullup_int, .pullup_ext, .soft_attach_n, .clk_req_n,
    .pll_lock, .remote_wakeup_request_n(wake_n), .usb_suspended, .frame_num, .ep_done, .func_addr,
    .func_enable, .port_status, .tx_data, .tx_valid, .tx_ready);
  // Verdict and end of run
  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // One comparison
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    @(negedge clk_sys);
    cpu_wr = 1'b0;
  endtask
  // One-cycle read strobe, answer one edge later
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge clk_sys);
    cpu_addr = a;
    cpu_rd = 1'b1;
    @(negedge clk_sys);
    cpu_rd = 1'b0;
    d = cpu_rdata;
  endtask
  // Bounded wait on suspended (0) or clock request (1)
  task automatic wait_on(input int which, input logic val, input int lim, output int cnt);
    cnt = 0;
    while (((which == 0) ? usb_suspended : clk_req_n) !== val && cnt < lim) begin
      @(negedge clk_sys);
      cnt++;
    end
    if (cnt >= lim) begin
      bad_count++;
      $display("Error wait %0d expected %b seen timeout", which, val);
      print_verdict();
    end
  endtask
  // Config, pull-ups, address and port status
  task automatic t_regs();
    rd(CFG_ADDR, v);
    chk("config reset", CFG_RESET, v);
    wr(CFG_ADDR, 8'h20);
    soft_attach_n = 1'b0;
    repeat (4) @(negedge clk_sys);
    chk("pullup ext", 2'b01, {pullup_int, pullup_ext});
    wr(CFG_ADDR, 8'h00);
    repeat (4) @(negedge clk_sys);
    chk("pullup int", 2'b10, {pullup_int, pullup_ext});
    wr(CMD_ADDR, CMD_SET_ADDR);
    wr(WDAT_ADDR, 8'hab);
    chk("address", 8'hab, {func_enable, func_addr});
    wr(CMD_ADDR, CMD_PORT_ST);
    wr(WDAT_ADDR, 8'h5c);
    wr(CMD_ADDR, CMD_PORT_ST);
    rd(RDAT_ADDR, v);
    chk("port read", 8'h5c, v);
    chk("port pins", 8'h5c, port_status);
    $display("Test registers done");
  endtask
  // Frame number, low byte first, then wraps
  task automatic t_frame();
    wr(CMD_ADDR, CMD_FRAME);
    rd(RDAT_ADDR, v);
    chk("frame low", frame_num[7:0], v);
    rd(RDAT_ADDR, v);
    chk("frame high", frame_num[10:8], v);
    rd(RDAT_ADDR, v);
    chk("frame again", frame_num[7:0], v);
    $display("Test frame done");
  endtask
  // Endpoint sizes, interrupt word and clearing
  task automatic t_ep();
    for (int e = 0; e < NUM_EP; e++) begin
      wr(CMD_ADDR, CMD_EP_SEL_LO + 8'(e));
      rd(RDAT_ADDR, v);
      chk("ep status", {(e > 4) ? 7'd8 : 7'd1, 1'b0}, v);
    end
    @(negedge clk_sys);
    done_req = 7'h04;
    @(negedge clk_sys);
    done_req = 7'h00;
    repeat (2) @(negedge clk_sys);
    chk("irq set", 1'b1, cpu_irq);
    wr(CMD_ADDR, CMD_INT_REG);
    rd(RDAT_ADDR, v);
    chk("int low", 8'h04, v);
    rd(RDAT_ADDR, v);
    chk("int high", 8'h00, v);
    wr(CMD_ADDR, CMD_EP_CLR_LO + 8'h02);
    rd(RDAT_ADDR, v);
    chk("ep clear status", 8'h02, v);
    chk("irq clear", 1'b0, cpu_irq);
    $display("Test endpoints done");
  endtask
  // Fill the buffer while stalled, then drain in order
  task automatic t_fifo();
    stall = 1'b1;
    wr(CMD_ADDR, CMD_BUFFER);
    for (int i = 0; i < 5; i++) begin
      wr(WDAT_ADDR, 8'ha0 + 8'(i));
    end
    chk("full", 1'b0, cpu_wr_ready);
    stall = 1'b0;
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      chk("tx valid", 1'b1, tx_valid);
      chk("tx data", 8'ha0 + 8'(i), tx_data);
      @(negedge clk_sys);
    end
    chk("empty", 1'b0, tx_valid);
    $display("Test buffer done");
  endtask
  // Suspend, clock release, host resume with and without handshake
  task automatic t_susp();
    bus_on = 1'b0;
    wait_on(0, 1'b1, SUSP + 10, n);
    chk("idle time", 1'b1, n >= SUSP - 1);
    wait_on(1, 1'b1, REL + 10, n);
    chk("release time", 1'b1, n >= REL - 1);
    pll_lock = 1'b0;
    chk("irq suspend", 1'b1, cpu_irq);
    wr(CMD_ADDR, CMD_DEV_ST);
    rd(RDAT_ADDR, v);
    chk("dev status", 8'h0c, v & 8'h0c);
    wr(CMD_ADDR, CMD_DEV_ST);
    rd(RDAT_ADDR, v);
    chk("dev cleared", 8'h04, v & 8'h1e);
    bus_on = 1'b1;
    wait_on(1, 1'b0, 6, n);
    repeat (10) @(negedge clk_sys);
    chk("await lock", 1'b1, usb_suspended);
    pll_lock = 1'b1;
    wait_on(0, 1'b0, 6, n);
    chk("no resume out", 1'b0, resume_drive);
    bus_on = 1'b0;
    wait_on(0, 1'b1, SUSP + 10, n);
    bus_on = 1'b1;
    wait_on(0, 1'b0, 6, n);
    chk("kept clock", 1'b0, clk_req_n);
    $display("Test suspend done");
  endtask
  // CPU wake before release, pin wake after release, bus reset
  task automatic t_wake();
    bus_on = 1'b0;
    wait_on(0, 1'b1, SUSP + 10, n);
    wr(CMD_ADDR, CMD_DEV_ST);
    wr(WDAT_ADDR, 8'h00);
    chk("early wake held", 1'b0, resume_drive);
    wait_on(0, 1'b0, REL + 10, n);
    chk("wake wait", 1'b1, n >= REL - 6);
    chk("resume sent", 2'b10, {resume_drive, clk_req_n});
    wait_on(0, 1'b1, SUSP + 20, n);
    wait_on(1, 1'b1, REL + 10, n);
    wake_n = 1'b0;
    wait_on(0, 1'b0, 8, n);
    chk("pin wake", 2'b10, {resume_drive, clk_req_n});
    wake_n = 1'b1;
    bus_on = 1'b1;
    bus_rst = 1'b1;
    repeat (4) @(negedge clk_sys);
    bus_rst = 1'b0;
    chk("reset address", 8'h00, {func_enable, func_addr});
    wr(CMD_ADDR, CMD_DEV_ST);
    rd(RDAT_ADDR, v);
    chk("bus reset bit", 8'h10, v & 8'h10);
    $display("Test wake done");
  endtask
  // Main sequence
  initial begin
    repeat (4) @(negedge clk_sys);
    rst_n = 1'b1;
    t_regs();
    t_frame();
    t_ep();
    t_fifo();
    t_susp();
    t_wake();
    print_verdict();
  end
endmodule // usb_fs_device_core_tb
